//--- logic/mssc_regs.svh
/*
 mode and supply control: offsets, field positions, codes, reset values and timing counts.
 assumes a 25 MHz core clock and a 32-bit lsb-first serial frame.
*/
`ifndef MSSC_REGS_SVH
`define MSSC_REGS_SVH

// frame layout
`define MSSC_FRAME_BITS      6'h20
`define MSSC_ADDR_MSB        6
`define MSSC_CMD_WRITE_BIT   7
`define MSSC_PAYLOAD_LSB     8
`define MSSC_PAYLOAD_MSB     23
`define MSSC_LOAD_AT_BIT     6'h07
`define MSSC_STATUS_OUT      8'h00
`define MSSC_CHECK_OUT       8'h5A

// register
`define MSSC_REG_ADDR        7'h01
`define MSSC_POR_VALUE       16'h0000
`define MSSC_RESTART_KEEP    16'h00A3
`define MSSC_USED_MASK       16'hC6A3

// field positions
`define MSSC_MODE_MSB        15
`define MSSC_MODE_LSB        14
`define MSSC_OVR_MSB         10
`define MSSC_OVR_LSB         9
`define MSSC_HYS_BIT         7
`define MSSC_PEAK_BIT        5
`define MSSC_RLVL_MSB        1
`define MSSC_RLVL_LSB        0

// mode codes
`define MSSC_MODE_NORMAL     2'h0
`define MSSC_MODE_SLEEP      2'h1
`define MSSC_MODE_STOP       2'h2
`define MSSC_MODE_SOFTRST    2'h3

// overvoltage reaction codes
`define MSSC_OVR_NONE        2'h0
`define MSSC_OVR_INT         2'h1
`define MSSC_OVR_RST         2'h2
`define MSSC_OVR_FAILSAFE    2'h3

// timing
`define MSSC_CLK_MHZ         25
`define MSSC_RST_PULSE_NS    2000
`define MSSC_INT_PULSE_NS    1000
`define MSSC_RST_PULSE_CYC   ((`MSSC_RST_PULSE_NS * `MSSC_CLK_MHZ + 999) / 1000)
`define MSSC_INT_PULSE_CYC   ((`MSSC_INT_PULSE_NS * `MSSC_CLK_MHZ + 999) / 1000)

`endif

//--- logic/mssc_pkg.sv
/*
 types shared by the mode and supply control files.
 assumes mssc_regs.svh for the numeric values.
*/
package mssc_pkg;
	typedef logic [1:0]  mssc_code_t;
	typedef logic [15:0] mssc_word_t;
	typedef enum logic [0:0] {SPI_IDLE, SPI_SHIFT} mssc_spi_state_e;
endpackage

//--- logic/mssc_spi_frame.sv
/*
 serial frame engine: pin synchronisers, lsb-first 32-bit shift in and out.
 assumes spi clock well below a quarter of the core clock; data taken on sclk rise,
 driven on sclk fall.
*/
`timescale 1ns/1ps
`include "mssc_regs.svh"

module mssc_spi_frame
	import mssc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// pins
	input  wire logic        spi_clk,
	input  wire logic        spi_sel_n,
	input  wire logic        spi_din,
	output logic             spi_dout,
	// register side
	input  wire mssc_word_t  tx_payload,
	output logic             load_pulse,
	output logic             frame_done,
	output logic [31:0]      rx_word
);
	logic [2:0]      pin_in;
	logic [2:0]      pin_f;
	logic [2:0]      s1;
	logic [2:0]      s2;
	logic [2:0]      s3;
	logic            clk_prev;
	logic            sel_prev;
	logic [5:0]      bit_cnt;
	logic [5:0]      next_bit_cnt;
	logic [31:0]     next_rx;
	mssc_word_t      payload_hold;
	mssc_word_t      next_payload_hold;
	logic            next_dout;
	logic            next_load;
	logic            next_done;
	logic [31:0]     tx_word;
	mssc_spi_state_e state;
	mssc_spi_state_e next_state;
	logic            rise;
	logic            fall;
	logic            sel_start;
	logic            sel_end;

	assign pin_in = {spi_din, spi_sel_n, spi_clk};

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_sync
			logic next_f;
			always_comb
			begin
				next_f = (s2[g] == s3[g]) ? s3[g] : pin_f[g];
			end
			always_ff @(posedge clock)
			begin
				// stages start at the idle level of their pin (clock low, others high),
				// so leaving reset never shows a false edge
				if (srst)
				begin
					s1[g]    <= (g != 0);
					s2[g]    <= (g != 0);
					s3[g]    <= (g != 0);
					pin_f[g] <= (g != 0);
				end
				else
				begin
					s1[g]    <= pin_in[g];
					s2[g]    <= s1[g];
					s3[g]    <= s2[g];
					pin_f[g] <= next_f;
				end
			end
		end
	endgenerate

	assign rise      = pin_f[0] & ~clk_prev;
	assign fall      = ~pin_f[0] & clk_prev;
	assign sel_start = ~pin_f[1] & sel_prev;
	assign sel_end   = pin_f[1] & ~sel_prev;
	assign tx_word   = {`MSSC_CHECK_OUT, payload_hold, `MSSC_STATUS_OUT};

	always_comb
	begin
		next_state        = state;
		next_bit_cnt      = bit_cnt;
		next_rx           = rx_word;
		next_payload_hold = payload_hold;
		next_dout         = spi_dout;
		next_load         = 1'b0;
		next_done         = 1'b0;
		case (state)
			SPI_IDLE:
			begin
				next_dout = 1'b0;
				if (sel_start)
				begin
					next_state        = SPI_SHIFT;
					next_bit_cnt      = 6'h00;
					next_payload_hold = `MSSC_POR_VALUE;
					next_dout         = tx_word[0];
				end
			end
			SPI_SHIFT:
			begin
				if (sel_end)
				begin
					next_state = SPI_IDLE;
					// short or long frames are dropped whole
					next_done  = (bit_cnt == `MSSC_FRAME_BITS);
					next_dout  = 1'b0;
				end
				else if (rise && bit_cnt <= `MSSC_FRAME_BITS)
				begin
					if (bit_cnt < `MSSC_FRAME_BITS)
						next_rx[bit_cnt[4:0]] = pin_f[2];
					// address is complete here, so the old contents go out
					if (bit_cnt == `MSSC_LOAD_AT_BIT)
					begin
						next_load         = 1'b1;
						next_payload_hold = tx_payload;
					end
					next_bit_cnt = bit_cnt + 6'h01;
				end
				else if (fall && bit_cnt < `MSSC_FRAME_BITS)
					next_dout = tx_word[bit_cnt[4:0]];
			end
			default:
				next_state = SPI_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state        <= SPI_IDLE;
			bit_cnt      <= 6'h00;
			rx_word      <= 32'h0000_0000;
			payload_hold <= 16'h0000;
			spi_dout     <= 1'b0;
			load_pulse   <= 1'b0;
			frame_done   <= 1'b0;
			clk_prev     <= 1'b0;
			sel_prev     <= 1'b1;
		end
		else
		begin
			state        <= next_state;
			bit_cnt      <= next_bit_cnt;
			rx_word      <= next_rx;
			payload_hold <= next_payload_hold;
			spi_dout     <= next_dout;
			load_pulse   <= next_load;
			frame_done   <= next_done;
			clk_prev     <= pin_f[0];
			sel_prev     <= pin_f[1];
		end
	end
endmodule

//--- logic/mssc_mode_supply_ctrl.sv
/*
 mode and supply control register with its serial access, mode decode,
 soft reset, restart handling and overvoltage reaction pulses.
 assumes restart_event and soft_reset_output_cfg come from core logic on clock;
 main_reg_overvoltage is an asynchronous comparator level.
*/
`timescale 1ns/1ps
`include "mssc_regs.svh"

module mssc_mode_supply_ctrl
	import mssc_pkg::*;
#(
	parameter int unsigned RST_PULSE_CYC = `MSSC_RST_PULSE_CYC,
	parameter int unsigned INT_PULSE_CYC = `MSSC_INT_PULSE_CYC
)
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// serial pins
	input  wire logic        spi_clk,
	input  wire logic        spi_sel_n,
	input  wire logic        spi_din,
	output logic             spi_dout,
	// device events and configuration
	input  wire logic        restart_event,
	input  wire logic        soft_reset_output_cfg,
	input  wire logic        main_reg_overvoltage,
	// mode outputs
	output logic             mode_normal,
	output logic             mode_sleep,
	output logic             mode_stop,
	output logic             soft_reset_pulse,
	// supply settings
	output mssc_code_t       main_reg_overvoltage_reaction,
	output logic             undervoltage_reset_hysteresis_sel,
	output logic             active_peak_threshold_sel,
	output mssc_code_t       undervoltage_reset_level_sel,
	// reaction outputs
	output logic             reset_output_n,
	output logic             interrupt_output_n,
	output logic             fail_safe_req
);
	localparam int RST_W = $clog2(RST_PULSE_CYC + 1);
	localparam int INT_W = $clog2(INT_PULSE_CYC + 1);

	mssc_code_t   mode;
	mssc_code_t   next_mode;
	mssc_code_t   next_ovr;
	logic         next_hys;
	logic         next_peak;
	mssc_code_t   next_rlvl;
	logic         next_soft;
	mssc_word_t   reg_value;
	mssc_word_t   tx_payload;
	logic         load_pulse;
	logic         frame_done;
	logic [31:0]  rx_word;
	mssc_word_t   wdata;
	logic         addr_hit;
	logic         wr;
	logic         wr_soft;
	logic         ov_s1;
	logic         ov_s2;
	logic         ov_s3;
	logic         ov_f;
	logic         ov_prev;
	logic         next_ov_f;
	logic         ov_rise;
	logic [RST_W-1:0] rst_cnt;
	logic [RST_W-1:0] next_rst_cnt;
	logic [INT_W-1:0] int_cnt;
	logic [INT_W-1:0] next_int_cnt;
	logic         next_fail;

	mssc_spi_frame u_frame (
		.clock      (clock),
		.srst       (srst),
		.spi_clk    (spi_clk),
		.spi_sel_n  (spi_sel_n),
		.spi_din    (spi_din),
		.spi_dout   (spi_dout),
		.tx_payload (tx_payload),
		.load_pulse (load_pulse),
		.frame_done (frame_done),
		.rx_word    (rx_word)
	);

	// readback is assembled, so reserved positions cannot hold anything
	assign reg_value = {mode, 3'h0, main_reg_overvoltage_reaction, 1'b0,
		undervoltage_reset_hysteresis_sel, 1'b0, active_peak_threshold_sel, 3'h0,
		undervoltage_reset_level_sel};

	assign addr_hit   = (rx_word[`MSSC_ADDR_MSB:0] == `MSSC_REG_ADDR);
	// other addresses belong to other register blocks and answer zero here
	assign tx_payload = addr_hit ? reg_value : `MSSC_POR_VALUE;
	assign wdata      = rx_word[`MSSC_PAYLOAD_MSB:`MSSC_PAYLOAD_LSB];
	assign wr         = frame_done && addr_hit && rx_word[`MSSC_CMD_WRITE_BIT];
	assign wr_soft    = wr && !restart_event
		&& (wdata[`MSSC_MODE_MSB:`MSSC_MODE_LSB] == `MSSC_MODE_SOFTRST);
	assign ov_rise    = ov_f & ~ov_prev;

	// register fields
	always_comb
	begin
		next_mode = mode;
		next_ovr  = main_reg_overvoltage_reaction;
		next_hys  = undervoltage_reset_hysteresis_sel;
		next_peak = active_peak_threshold_sel;
		next_rlvl = undervoltage_reset_level_sel;
		next_soft = 1'b0;
		// restart is hardware and outranks a write landing in the same cycle
		if (restart_event)
		begin
			next_mode = `MSSC_MODE_NORMAL;
			next_ovr  = `MSSC_OVR_NONE;
		end
		else if (wr_soft)
		begin
			next_mode = `MSSC_MODE_NORMAL;
			next_ovr  = `MSSC_OVR_NONE;
			next_hys  = 1'b0;
			next_peak = 1'b0;
			next_rlvl = 2'h0;
			next_soft = 1'b1;
		end
		else if (wr)
		begin
			if (!(mode == `MSSC_MODE_STOP
				&& wdata[`MSSC_MODE_MSB:`MSSC_MODE_LSB] == `MSSC_MODE_SLEEP))
				next_mode = wdata[`MSSC_MODE_MSB:`MSSC_MODE_LSB];
			next_ovr  = wdata[`MSSC_OVR_MSB:`MSSC_OVR_LSB];
			next_hys  = wdata[`MSSC_HYS_BIT];
			next_peak = wdata[`MSSC_PEAK_BIT];
			next_rlvl = wdata[`MSSC_RLVL_MSB:`MSSC_RLVL_LSB];
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mode                              <= `MSSC_MODE_NORMAL;
			main_reg_overvoltage_reaction     <= `MSSC_OVR_NONE;
			undervoltage_reset_hysteresis_sel <= 1'b0;
			active_peak_threshold_sel         <= 1'b0;
			undervoltage_reset_level_sel      <= 2'h0;
			soft_reset_pulse                  <= 1'b0;
			mode_normal                       <= 1'b1;
			mode_sleep                        <= 1'b0;
			mode_stop                         <= 1'b0;
		end
		else
		begin
			mode                              <= next_mode;
			main_reg_overvoltage_reaction     <= next_ovr;
			undervoltage_reset_hysteresis_sel <= next_hys;
			active_peak_threshold_sel         <= next_peak;
			undervoltage_reset_level_sel      <= next_rlvl;
			soft_reset_pulse                  <= next_soft;
			mode_normal                       <= (next_mode == `MSSC_MODE_NORMAL);
			mode_sleep                        <= (next_mode == `MSSC_MODE_SLEEP);
			mode_stop                         <= (next_mode == `MSSC_MODE_STOP);
		end
	end

	// overvoltage comparator: three stages, a change counts when stages two and three agree
	always_comb
	begin
		next_ov_f = (ov_s2 == ov_s3) ? ov_s3 : ov_f;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ov_s1   <= 1'b0;
			ov_s2   <= 1'b0;
			ov_s3   <= 1'b0;
			ov_f    <= 1'b0;
			ov_prev <= 1'b0;
		end
		else
		begin
			ov_s1   <= main_reg_overvoltage;
			ov_s2   <= ov_s1;
			ov_s3   <= ov_s2;
			ov_f    <= next_ov_f;
			ov_prev <= ov_f;
		end
	end

	// reaction pulses; a new event restarts the pulse rather than stacking
	always_comb
	begin
		next_rst_cnt = rst_cnt;
		next_int_cnt = int_cnt;
		next_fail    = 1'b0;
		if (rst_cnt != '0)
			next_rst_cnt = rst_cnt - 1'b1;
		if (int_cnt != '0)
			next_int_cnt = int_cnt - 1'b1;
		if (wr_soft && !soft_reset_output_cfg)
			next_rst_cnt = RST_W'(RST_PULSE_CYC);
		if (ov_rise)
		begin
			case (main_reg_overvoltage_reaction)
				`MSSC_OVR_INT:      next_int_cnt = INT_W'(INT_PULSE_CYC);
				`MSSC_OVR_RST:      next_rst_cnt = RST_W'(RST_PULSE_CYC);
				`MSSC_OVR_FAILSAFE: next_fail = 1'b1;
				default:            next_fail = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rst_cnt            <= '0;
			int_cnt            <= '0;
			reset_output_n     <= 1'b1;
			interrupt_output_n <= 1'b1;
			fail_safe_req      <= 1'b0;
		end
		else
		begin
			rst_cnt            <= next_rst_cnt;
			int_cnt            <= next_int_cnt;
			reset_output_n     <= (next_rst_cnt == '0);
			interrupt_output_n <= (next_int_cnt == '0);
			fail_safe_req      <= next_fail;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence soft_cmd_s;
		wr_soft && !soft_reset_output_cfg;
	endsequence

	sequence pin_low8_s;
		!reset_output_n [*8];
	endsequence

	mode_decode_a: assert property (mode_sleep == (mode == `MSSC_MODE_SLEEP)
		&& mode_stop == (mode == `MSSC_MODE_STOP))
		else $error("mode outputs disagree with mode field");

	soft_clear_a: assert property (wr_soft |=> reg_value == `MSSC_POR_VALUE
		&& soft_reset_pulse && mode_normal)
		else $error("soft reset did not clear register");

	soft_pin_a: assert property (soft_cmd_s |=> pin_low8_s)
		else $error("reset pin not held low after soft reset");

	soft_nopin_a: assert property (wr_soft && soft_reset_output_cfg && reset_output_n
		&& !ov_rise |=> reset_output_n)
		else $error("reset pin pulled although configured off");

	ov_int_a: assert property (ov_rise && main_reg_overvoltage_reaction == `MSSC_OVR_INT
		|=> !interrupt_output_n)
		else $error("overvoltage interrupt missing");

	ov_fail_a: assert property (ov_rise == 1'b0 |=> !fail_safe_req)
		else $error("fail-safe request without overvoltage event");

	reserved_zero_a: assert property ((reg_value & ~`MSSC_USED_MASK) == 16'h0000)
		else $error("reserved bits not zero");

	restart_keep_a: assert property (restart_event |=> mode == `MSSC_MODE_NORMAL
		&& main_reg_overvoltage_reaction == `MSSC_OVR_NONE
		&& (reg_value & `MSSC_RESTART_KEEP) == ($past(reg_value) & `MSSC_RESTART_KEEP))
		else $error("restart value wrong");

	stop_sleep_a: assert property (wr && !restart_event && mode == `MSSC_MODE_STOP
		&& wdata[`MSSC_MODE_MSB:`MSSC_MODE_LSB] == `MSSC_MODE_SLEEP |=> mode_stop)
		else $error("serial command moved stop to sleep");

	fields_write_a: assert property (wr && !restart_event && !wr_soft
		|=> undervoltage_reset_hysteresis_sel == $past(wdata[`MSSC_HYS_BIT])
		&& active_peak_threshold_sel == $past(wdata[`MSSC_PEAK_BIT]))
		else $error("written settings not stored");

	readback_old_a: assert property (!wr && !restart_event |=> $stable(reg_value))
		else $error("register changed before its frame ended");

	payload_old_a: assert property (load_pulse && addr_hit
		|=> u_frame.payload_hold == $past(reg_value))
		else $error("readback is not the stored value");
endmodule

//--- test/mssc_spi_master.sv
/*
 serial master model: one 32-bit lsb-first frame per call, captures the reply word.
 assumes the bench core clock; spi half period of ten core cycles, clock idle low.
*/
`timescale 1ns/1ps

module mssc_spi_master
(
	// core clock
	input  wire logic        clock,
	// serial pins
	output logic             spi_clk,
	output logic             spi_sel_n,
	output logic             spi_din,
	input  wire logic        spi_dout,
	// captured reply
	output logic             rx_valid,
	output logic [31:0]      rx_word
);
	localparam int HALF = 10;

	initial
	begin
		spi_clk = 1'b0;
		spi_sel_n = 1'b1;
		spi_din = 1'b1;
		rx_valid = 1'b0;
		rx_word = 32'h0000_0000;
	end

	task automatic half();
		repeat (HALF) @(posedge clock);
		#1;
	endtask

	task automatic xfer(input logic [6:0] addr, input logic wr, input logic [15:0] data);
		logic [31:0] tx;
		tx = {8'hA5, data, wr, addr};
		@(posedge clock);
		#1 spi_sel_n = 1'b0;
		spi_din = tx[0];
		half();
		for (int i = 0; i < 32; i++)
		begin
			spi_clk = 1'b1;
			rx_word[i] = spi_dout;
			half();
			spi_clk = 1'b0;
			// past the last bit the line shows junk, not a held value
			spi_din = (i < 31) ? tx[i + 1] : ~tx[31];
			half();
		end
		spi_sel_n = 1'b1;
		half();
		rx_valid = 1'b1;
		@(posedge clock);
		#1 rx_valid = 1'b0;
		half();
	endtask
endmodule

//--- test/tb.sv
/*
 bench for the mode and supply control register: serial frames, events, pulse lengths.
 assumes the serial master model and shortened pulse parameters of 8 and 4 cycles.
*/
`timescale 1ns/1ps
`include "mssc_regs.svh"

module tb;
	import mssc_pkg::*;

	logic        clock;
	logic        srst;
	logic        spi_clk;
	logic        spi_sel_n;
	logic        spi_din;
	logic        spi_dout;
	logic        restart_event;
	logic        soft_reset_output_cfg;
	logic        main_reg_overvoltage;
	logic        mode_normal;
	logic        mode_sleep;
	logic        mode_stop;
	logic        soft_reset_pulse;
	mssc_code_t  main_reg_overvoltage_reaction;
	logic        undervoltage_reset_hysteresis_sel;
	logic        active_peak_threshold_sel;
	mssc_code_t  undervoltage_reset_level_sel;
	logic        reset_output_n;
	logic        interrupt_output_n;
	logic        fail_safe_req;
	logic        rx_valid;
	logic [31:0] rx_word;
	mssc_word_t  model;
	logic [31:0] exp_q[$];
	int          compares = 0;
	int          miscompares = 0;
	int          rst_low = 0;
	int          int_low = 0;
	int          rst_run = 0;
	int          int_run = 0;
	int          fs_cnt = 0;
	int          sr_cnt = 0;
	int unsigned seed;

	mssc_mode_supply_ctrl #(.RST_PULSE_CYC(8), .INT_PULSE_CYC(4)) dut_u (.clock(clock),
		.srst(srst), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .spi_din(spi_din),
		.spi_dout(spi_dout), .restart_event(restart_event),
		.soft_reset_output_cfg(soft_reset_output_cfg),
		.main_reg_overvoltage(main_reg_overvoltage), .mode_normal(mode_normal),
		.mode_sleep(mode_sleep), .mode_stop(mode_stop), .soft_reset_pulse(soft_reset_pulse),
		.main_reg_overvoltage_reaction(main_reg_overvoltage_reaction),
		.undervoltage_reset_hysteresis_sel(undervoltage_reset_hysteresis_sel),
		.active_peak_threshold_sel(active_peak_threshold_sel),
		.undervoltage_reset_level_sel(undervoltage_reset_level_sel),
		.reset_output_n(reset_output_n), .interrupt_output_n(interrupt_output_n),
		.fail_safe_req(fail_safe_req));

	mssc_spi_master master_u (.clock(clock), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
		.spi_din(spi_din), .spi_dout(spi_dout), .rx_valid(rx_valid), .rx_word(rx_word));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic check_outs();
		check({mode_stop, mode_sleep, mode_normal}, {model[15:14] == 2'h2,
			model[15:14] == 2'h1, model[15:14] == 2'h0});
		check(main_reg_overvoltage_reaction, model[10:9]);
		check(undervoltage_reset_hysteresis_sel, model[7]);
		check(active_peak_threshold_sel, model[5]);
		check(undervoltage_reset_level_sel, model[1:0]);
	endtask

	task automatic xfer(input logic [6:0] a, input logic wr, input logic [15:0] d);
		mssc_word_t nxt;
		exp_q.push_back({`MSSC_CHECK_OUT, (a == `MSSC_REG_ADDR) ? model : 16'h0000,
			`MSSC_STATUS_OUT});
		master_u.xfer(a, wr, d);
		nxt = d & `MSSC_USED_MASK;
		if (model[15:14] == 2'h2 && d[15:14] == 2'h1)
			nxt[15:14] = 2'h2;
		if (d[15:14] == 2'h3)
			nxt = 16'h0000;
		if (wr && a == `MSSC_REG_ADDR)
			model = nxt;
	endtask

	always @(posedge clock)
	begin
		if (rx_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(rx_word, 32'hFFFF_FFFF);
			else
				check(rx_word, exp_q.pop_front());
		end
	end

	// pulse widths measured at the pins, not taken from the design
	always @(posedge clock)
	begin
		rst_low <= (reset_output_n === 1'b0) ? rst_low + 1 : 0;
		int_low <= (interrupt_output_n === 1'b0) ? int_low + 1 : 0;
		if (reset_output_n === 1'b1 && rst_low > 0)
			rst_run <= rst_low;
		if (interrupt_output_n === 1'b1 && int_low > 0)
			int_run <= int_low;
		if (fail_safe_req === 1'b1)
			fs_cnt <= fs_cnt + 1;
		if (soft_reset_pulse === 1'b1)
			sr_cnt <= sr_cnt + 1;
	end

	task automatic clear_counts();
		rst_run = 0;
		int_run = 0;
		fs_cnt = 0;
		sr_cnt = 0;
	endtask

	initial
	begin
		repeat (90000) @(posedge clock);
		miscompares++;
		stop_test();
	end

	initial
	begin
		logic [1:0] modes [5];
		modes = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
		srst = 1'b1;
		restart_event = 1'b0;
		soft_reset_output_cfg = 1'b0;
		main_reg_overvoltage = 1'b0;
		model = 16'h0000;
		seed = $urandom(54397);
		repeat (16) @(posedge clock);
		#1 srst = 1'b0;
		repeat (4) @(posedge clock);
		check_outs();
		check(reset_output_n, 1'b1);
		xfer(7'h01, 1'b0, 16'hFFFF);
		for (int i = 0; i < 6; i++)
		begin
			xfer(7'h01, 1'b1, $urandom & 16'h3FFF);
			check_outs();
		end
		xfer(7'h01, 1'b1, 16'h3FFF);
		xfer(7'h02, 1'b1, 16'h0000);
		check_outs();
		foreach (modes[i])
		begin
			xfer(7'h01, 1'b1, {modes[i], 14'h0000});
			check_outs();
		end
		for (int c = 0; c < 4; c++)
		begin
			xfer(7'h01, 1'b1, {5'h00, c[1:0], 9'h000});
			clear_counts();
			main_reg_overvoltage = 1'b1;
			repeat (30) @(posedge clock);
			#1 main_reg_overvoltage = 1'b0;
			repeat (10) @(posedge clock);
			check(int_run, (c == 1) ? 4 : 0);
			check(rst_run, (c == 2) ? 8 : 0);
			check(fs_cnt, (c == 3) ? 1 : 0);
		end
		xfer(7'h01, 1'b1, 16'h86A3);
		@(posedge clock);
		#1 restart_event = 1'b1;
		@(posedge clock);
		#1 restart_event = 1'b0;
		repeat (3) @(posedge clock);
		model = model & `MSSC_RESTART_KEEP;
		check_outs();
		@(posedge clock);
		#1 srst = 1'b1;
		repeat (2) @(posedge clock);
		#1 srst = 1'b0;
		model = 16'h0000;
		repeat (4) @(posedge clock);
		#1;
		check_outs();
		check(reset_output_n, 1'b1);
		for (int c = 0; c < 2; c++)
		begin
			xfer(7'h01, 1'b1, 16'h06A3);
			clear_counts();
			soft_reset_output_cfg = c[0];
			xfer(7'h01, 1'b1, 16'hC000);
			repeat (20) @(posedge clock);
			check(sr_cnt, 1);
			check(rst_run, (c == 0) ? 8 : 0);
			check_outs();
		end
		xfer(7'h01, 1'b0, 16'h0000);
		repeat (5) @(posedge clock);
		stop_test();
	end
endmodule
